/* rtl/iop_cfg.svh */
// Register offsets, field positions, reset values and timing counts of the IO protection control block
`ifndef IOP_CFG_SVH
`define IOP_CFG_SVH

// ------------------------------------------------------------
// Register word indices; the byte offset is four times the index
// ------------------------------------------------------------
`define IOP_OFS_CTRL     4'h0
`define IOP_OFS_FLUSH    4'h1
`define IOP_OFS_STATUS   4'h2
`define IOP_OFS_MASK     4'h3
`define IOP_OFS_FAIL     4'h4

// ------------------------------------------------------------
// Control field positions
// ------------------------------------------------------------
`define IOP_CTL_EN       0
`define IOP_CTL_PM_LO    1
`define IOP_CTL_CE       3
`define IOP_CTL_GS       4
`define IOP_CTL_DM       5
`define IOP_CTL_WP       6
`define IOP_CTL_AU       7
`define IOP_CTL_HP_LO    8
`define IOP_CTL_SIV      10
`define IOP_CTL_DP       11

// ------------------------------------------------------------
// Flush field positions, status bits
// ------------------------------------------------------------
`define IOP_FL_ALL       0
`define IOP_FL_GRP       1
`define IOP_FL_SEL_LO    4
`define IOP_ST_TE        0
`define IOP_ST_AD        1
`define IOP_ST_FL        2
`define IOP_ST_FC        3
`define IOP_ST_DE        4
`define IOP_ST_PE        5

// ------------------------------------------------------------
// Reset values and timing
// ------------------------------------------------------------
`define IOP_CTRL_RST     12'h000
`define IOP_MASK_RST     6'h00
`define IOP_PM_BITMAP    2'h0
`define IOP_PM_IOMMU     2'h1
`define IOP_FLUSH_CYC    6'h20
`define IOP_EN_DELAY     2'h2

`endif

/* rtl/iop_pkg.sv */
// Types shared by the IO protection control block
package iop_pkg;
	// Access decision request from the checking datapath
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [31:0] addr;
		logic [3:0]  initiator;
		logic [3:0]  group;
		logic        in_window;
		logic        grp_active;
		logic        grp_pass;
		logic        bitmap_ok;
	} iop_req_t;

	// Lookup control towards the cache/TLB and table fetch engine
	typedef struct packed {
		logic       prefetch_en;
		logic       keep_invalid;
		logic [1:0] fetch_hprot;
		logic       cache_en;
		logic       group_in_set;
		logic [1:0] scheme;
	} iop_lookup_t;

	// Flush sequencer states
	typedef enum logic [1:0] {
		IOP_FL_IDLE,
		IOP_FL_RUN,
		IOP_FL_DONE
	} iop_flush_state_t;
endpackage

/* rtl/iop_ctrl.sv */
// IO protection control, flush, status and mask registers with access decision
// Operation
// - Prefetch_off set blocks all prefetching
// - Keep_invalid_entries buffers invalid page entries
// - Table fetch HPROT[3:2] from control field
// - Failing register updates per log_every_denial policy
// - Write_only_check lets reads pass unchecked
// - IOMMU mode ignores write_only_check
// - Diagnostic_request enters diagnostic mode, stops forwarding
// - Group_in_set_index adds group to set address
// - Lookup buffer runs only when enabled
// - Protection_scheme selects bitmap or IOMMU mode
// - Unit_on enables; readback shows effective state
// - Unit_on change held off while busy
// - Group flush uses select field, self-clears
// - Whole flush reads one until finished
// - Purge_begun_flag sticky, write one clears
// - Flush_done_flag sticky, write one clears
// - Access_refused_flag sticky on denial
// - Table fetch error sets lookup_fault, blocks
// - Parity error sets sticky ram_parity_flag
// - Diag_active_flag shows diagnostic mode
// - Parity mask raises interrupt on rise
// - Mask bits three to zero gate flags
// - Failing register holds address, write, initiator
`timescale 1ns/1ps
`include "iop_cfg.svh"

module iop_ctrl (
	input  wire logic               clk_i,          // System clock
	input  wire logic               rst_i,          // Synchronous reset
	// Wishbone slave
	input  wire logic               wb_cyc_i,
	input  wire logic               wb_stb_i,
	input  wire logic               wb_we_i,
	input  wire logic [7:0]         wb_adr_i,
	input  wire logic [3:0]         wb_sel_i,
	input  wire logic [31:0]        wb_dat_i,
	output logic      [31:0]        wb_dat_o,
	output logic                    wb_ack_o,
	// Access checking
	input  wire iop_pkg::iop_req_t  req_i,          // Access to decide this cycle
	input  wire logic               fetch_err_i,    // ERROR on table fetch
	input  wire logic               parity_err_i,   // Cache RAM parity error
	input  wire logic               busy_i,         // Datapath occupied
	output logic                    grant_o,        // Access forwarded
	output logic                    deny_o,         // Access blocked
	output logic                    check_o,        // Access was checked
	output iop_pkg::iop_lookup_t    lookup_o,       // Lookup engine control
	output logic      [3:0]         flush_set_o,    // Set address of flush
	output logic                    flush_grp_o,    // Flush limited to a group
	output logic                    flush_busy_o,   // Flush in progress
	output logic      [3:0]         set_group_o,    // Group part of set address
	output logic                    irq_o           // Interrupt
);

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	logic [11:0]  ctrl_q;          // Control bits 11:0, bit 0 is request
	logic         en_q;            // Effective unit enable
	logic [1:0]   en_cnt_q;        // Enable settle counter
	logic [5:0]   stat_q;          // Sticky flags, bit 4 unused here
	logic         diag_q;          // Effective diagnostic mode
	logic [5:0]   mask_q;          // Interrupt masks
	logic [31:0]  fail_q;          // Failing access record
	logic [5:0]   stat_prev_q;     // Flags last cycle, for rise detect
	logic         all_q;           // Whole flush command pending
	logic         grp_q;           // Group flush command pending
	logic [3:0]   fsel_q;          // Flush group select
	logic [5:0]   fcnt_q;          // Flush walk counter
	iop_pkg::iop_flush_state_t fst_q; // Flush sequencer

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic        wr_hit;           // Write strobe this cycle
	logic [3:0]  wr_idx;           // Register index
	logic [31:0] rd_val;           // Read mux

	// Register index of a byte address; unaligned falls out of map
	function automatic logic [3:0] reg_idx(input logic [7:0] a);
		reg_idx = (a[1:0] == 2'h0 && a[7:5] == 3'h0) ? a[5:2] : 4'hf;
	endfunction

	assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
	assign wr_idx = reg_idx(wb_adr_i);

	// Read mux; unmapped addresses read zero
	always_comb begin
		rd_val = 32'h0000_0000;
		case (reg_idx(wb_adr_i))
			`IOP_OFS_CTRL:   rd_val = {20'h00000, ctrl_q[11:1], en_q};
			`IOP_OFS_FLUSH:  rd_val = {24'h000000, fsel_q, 2'h0, grp_q, all_q};
			`IOP_OFS_STATUS: rd_val = {26'h0000000, stat_q[5], diag_q, stat_q[3:0]};
			`IOP_OFS_MASK:   rd_val = {26'h0000000, mask_q};
			`IOP_OFS_FAIL:   rd_val = fail_q;
			default:         rd_val = 32'h0000_0000;
		endcase
	end

	// Ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			wb_dat_o <= rd_val;
		end
	end

	// ------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------
	// Only the low byte lanes carry fields; byte 1 holds bits 11:8
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= `IOP_CTRL_RST;
		end else if (wr_hit && wr_idx == `IOP_OFS_CTRL) begin
			ctrl_q[7:0] <= wb_dat_i[7:0];
			if (wb_sel_i[1]) begin
				ctrl_q[11:8] <= wb_dat_i[11:8];
			end
		end
	end

	// Diagnostic mode follows request once datapath is quiet
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			diag_q <= 1'b0;
		end else if (!ctrl_q[`IOP_CTL_DM]) begin
			diag_q <= 1'b0;
		end else if (!busy_i && fst_q == iop_pkg::IOP_FL_IDLE) begin
			diag_q <= 1'b1;
		end
	end

	// Enable takes effect after a settle delay, held off while busy
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en_q     <= 1'b0;
			en_cnt_q <= 2'h0;
		end else if (ctrl_q[`IOP_CTL_EN] == en_q || diag_q || busy_i
			|| fst_q != iop_pkg::IOP_FL_IDLE) begin
			en_cnt_q <= 2'h0;
		end else if (en_cnt_q == `IOP_EN_DELAY) begin
			en_q     <= ctrl_q[`IOP_CTL_EN];
			en_cnt_q <= 2'h0;
		end else begin
			en_cnt_q <= en_cnt_q + 2'h1;
		end
	end

	// ------------------------------------------------------------
	// Lookup engine control
	// ------------------------------------------------------------
	// Registered so every output comes from a flop
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lookup_o    <= '0;
			set_group_o <= 4'h0;
		end else begin
			lookup_o.prefetch_en  <= !ctrl_q[`IOP_CTL_DP];
			// Invalid entries only kept when a buffer is running
			lookup_o.keep_invalid <= ctrl_q[`IOP_CTL_SIV] && ctrl_q[`IOP_CTL_CE];
			lookup_o.fetch_hprot  <= ctrl_q[`IOP_CTL_HP_LO +: 2];
			lookup_o.cache_en     <= ctrl_q[`IOP_CTL_CE];
			lookup_o.group_in_set <= ctrl_q[`IOP_CTL_GS];
			lookup_o.scheme       <= ctrl_q[`IOP_CTL_PM_LO +: 2];
			set_group_o <= ctrl_q[`IOP_CTL_GS] ? req_i.group : 4'h0;
		end
	end

	// ------------------------------------------------------------
	// Access decision
	// ------------------------------------------------------------
	logic need_chk;   // Access must be checked
	logic chk_fail;   // Check refuses it
	logic do_deny;    // Denied this cycle
	logic do_fault;   // Fetch error blocks it

	always_comb begin
		need_chk = 1'b0;
		chk_fail = 1'b0;
		if (ctrl_q[`IOP_CTL_PM_LO +: 2] == `IOP_PM_IOMMU) begin
			// Write-only check ignored here
			need_chk = req_i.in_window && req_i.grp_active && !req_i.grp_pass;
			chk_fail = !req_i.grp_active || (need_chk && !req_i.bitmap_ok);
		end else begin
			need_chk = req_i.grp_active && !req_i.grp_pass
				&& !(ctrl_q[`IOP_CTL_WP] && !req_i.write);
			chk_fail = !req_i.grp_active || (need_chk && !req_i.bitmap_ok);
		end
	end

	assign do_fault = en_q && req_i.valid && !diag_q && fetch_err_i;
	assign do_deny  = en_q && req_i.valid && !diag_q && (chk_fail || fetch_err_i);

	// Grant/deny strobes; nothing forwarded in diagnostic mode
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			grant_o <= 1'b0;
			deny_o  <= 1'b0;
			check_o <= 1'b0;
		end else begin
			grant_o <= req_i.valid && !diag_q && !do_deny;
			deny_o  <= do_deny;
			check_o <= en_q && req_i.valid && !diag_q && need_chk;
		end
	end

	// Failing record kept under the update policy
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fail_q <= 32'h0000_0000;
		end else if (do_deny && (ctrl_q[`IOP_CTL_AU] || !stat_q[`IOP_ST_AD])) begin
			fail_q <= {req_i.addr[31:5], req_i.write, req_i.initiator};
		end
	end

	// ------------------------------------------------------------
	// Flush sequencer
	// ------------------------------------------------------------
	logic fl_start;   // A flush begins this cycle
	logic fl_end;     // A flush finishes this cycle

	assign fl_start = fst_q == iop_pkg::IOP_FL_IDLE && (all_q || grp_q);
	assign fl_end   = fst_q == iop_pkg::IOP_FL_DONE;

	// Commands latch on write of one and self-clear at completion
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			all_q  <= 1'b0;
			grp_q  <= 1'b0;
			fsel_q <= 4'h0;
		end else if (fl_end) begin
			all_q <= 1'b0;
			grp_q <= 1'b0;
		end else if (wr_hit && wr_idx == `IOP_OFS_FLUSH && fst_q == iop_pkg::IOP_FL_IDLE) begin
			all_q  <= wb_dat_i[`IOP_FL_ALL];
			grp_q  <= wb_dat_i[`IOP_FL_GRP];
			fsel_q <= wb_dat_i[`IOP_FL_SEL_LO +: 4];
		end
	end

	// Walk of the cache lines; a group flush touches one set slice
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fst_q  <= iop_pkg::IOP_FL_IDLE;
			fcnt_q <= 6'h00;
		end else begin
			case (fst_q)
				iop_pkg::IOP_FL_IDLE: begin
					fcnt_q <= 6'h00;
					if (fl_start) begin
						fst_q <= iop_pkg::IOP_FL_RUN;
					end
				end
				iop_pkg::IOP_FL_RUN: begin
					fcnt_q <= fcnt_q + 6'h01;
					if (grp_q && !all_q || fcnt_q == `IOP_FLUSH_CYC - 6'h01) begin
						fst_q <= iop_pkg::IOP_FL_DONE;
					end
				end
				iop_pkg::IOP_FL_DONE: fst_q <= iop_pkg::IOP_FL_IDLE;
				default:              fst_q <= iop_pkg::IOP_FL_IDLE;
			endcase
		end
	end

	// Flush outputs to the lookup store
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flush_busy_o <= 1'b0;
			flush_grp_o  <= 1'b0;
			flush_set_o  <= 4'h0;
		end else begin
			flush_busy_o <= fst_q == iop_pkg::IOP_FL_RUN;
			flush_grp_o  <= grp_q && !all_q;
			flush_set_o  <= (grp_q && !all_q) ? fsel_q : fcnt_q[3:0];
		end
	end

	// ------------------------------------------------------------
	// Sticky status flags
	// ------------------------------------------------------------
	logic [5:0] set_ev;   // Hardware set events
	logic [5:0] clr_ev;   // Software clear by writing one

	assign set_ev = {parity_err_i, 1'b0, fl_end, fl_start, do_deny, do_fault};
	assign clr_ev = (wr_hit && wr_idx == `IOP_OFS_STATUS) ? (wb_dat_i[5:0] & 6'h2f) : 6'h00;

	// Set wins over a clear in the same cycle
	genvar g;
	generate
		for (g = 0; g < 6; g++) begin : g_flag
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					stat_q[g] <= 1'b0;
				end else if (set_ev[g]) begin
					stat_q[g] <= 1'b1;
				end else if (clr_ev[g]) begin
					stat_q[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Masks and interrupt
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_q <= `IOP_MASK_RST;
		end else if (wr_hit && wr_idx == `IOP_OFS_MASK) begin
			mask_q <= wb_dat_i[5:0] & 6'h2f;
		end
	end

	// One-cycle pulse on a masked zero-to-one flag transition
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stat_prev_q <= 6'h00;
			irq_o       <= 1'b0;
		end else begin
			stat_prev_q <= stat_q;
			irq_o <= |(stat_q & ~stat_prev_q & mask_q);
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_flag_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
		do_deny |=> stat_q[`IOP_ST_AD]) else $error("Denial did not set flag");
	a_flag_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		clr_ev[`IOP_ST_FC] && !set_ev[`IOP_ST_FC] |=> !stat_q[`IOP_ST_FC]) else $error("Flag not cleared");
	a_flush_begin: assert property (@(posedge clk_i) disable iff (rst_i)
		fl_start |=> stat_q[`IOP_ST_FL] && fst_q == iop_pkg::IOP_FL_RUN) else $error("Flush start lost");
	a_flush_ends: assert property (@(posedge clk_i) disable iff (rst_i)
		fl_start |-> ##[2:34] !all_q && !grp_q) else $error("Flush never finished");
	a_diag_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
		diag_q |=> !grant_o) else $error("Access forwarded in diagnostic mode");
	a_fail_policy: assert property (@(posedge clk_i) disable iff (rst_i)
		do_deny && !ctrl_q[`IOP_CTL_AU] && stat_q[`IOP_ST_AD] |=> $stable(fail_q)) else $error("Record overwritten");
	a_irq_parity: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(stat_q[`IOP_ST_PE]) && mask_q[5] |=> irq_o) else $error("Parity interrupt missing");
	a_en_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		diag_q |=> $stable(en_q)) else $error("Enable changed in diagnostic mode");
	a_iommu_wp: assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl_q[2:1] == `IOP_PM_IOMMU && req_i.in_window && req_i.grp_active && !req_i.grp_pass
		|-> need_chk) else $error("IOMMU access not checked");
	a_prefetch: assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl_q[`IOP_CTL_DP] |=> !lookup_o.prefetch_en) else $error("Prefetch left on");
	// A group flush walks a single set slice, so it must end quickly
	a_group_flush: assert property (@(posedge clk_i) disable iff (rst_i)
		fl_start && grp_q && !all_q |-> ##2 fl_end) else $error("Group flush too long");
	// Same-cycle set and clear must leave the flag standing
	a_set_beats_clr: assert property (@(posedge clk_i) disable iff (rst_i)
		set_ev[`IOP_ST_AD] && clr_ev[`IOP_ST_AD] |=> stat_q[`IOP_ST_AD]) else $error("Event lost to clear");
	// Lookup store stays off while its enable bit is low
	a_cache_off: assert property (@(posedge clk_i) disable iff (rst_i)
		!ctrl_q[`IOP_CTL_CE] |=> !lookup_o.cache_en && !lookup_o.keep_invalid) else $error("Cache left on");
	// Diagnostic flag drops once the request is withdrawn
	a_diag_leave: assert property (@(posedge clk_i) disable iff (rst_i)
		!ctrl_q[`IOP_CTL_DM] |=> !diag_q) else $error("Diagnostic mode kept");

endmodule

/* sim/iop_far_model.sv */
// Bus masters and table memory facing the IO protection control block
`timescale 1ns/1ps

module iop_far_model (
	input  wire logic          clk_i,        // System clock
	input  wire logic          grant_i,      // Access forwarded
	input  wire logic          deny_i,       // Access blocked
	output iop_pkg::iop_req_t  req_o,        // Access offered to the unit
	output logic               fetch_err_o,  // ERROR answer on a table fetch
	output logic               parity_err_o, // Cache RAM parity fault
	output logic               busy_o        // Datapath occupied
);
	// ------------------------------------------------------------
	// Idle at time zero
	// ------------------------------------------------------------
	initial begin
		req_o = '0;
		fetch_err_o = 1'b0;
		parity_err_o = 1'b0;
		busy_o = 1'b0;
	end

	// ------------------------------------------------------------
	// One access, with an optional ERROR from memory on its fetch
	// ------------------------------------------------------------
	task automatic access(input iop_pkg::iop_req_t r, input logic fe, output logic g, output logic d);
		@(posedge clk_i);
		req_o <= r;
		fetch_err_o <= fe;
		@(posedge clk_i);
		// Released fields show garbage, never the old access
		req_o <= iop_pkg::iop_req_t'(~r);
		fetch_err_o <= 1'b0;
		#1;
		g = grant_i;
		d = deny_i;
	endtask

	// Single-cycle parity fault from the cache RAM
	task automatic parity();
		@(posedge clk_i);
		parity_err_o <= 1'b1;
		@(posedge clk_i);
		parity_err_o <= 1'b0;
	endtask

	// Datapath occupancy, which may hold off enable changes
	task automatic hold(input logic b);
		@(posedge clk_i);
		busy_o <= b;
	endtask
endmodule

/* sim/tb.sv */
// Self-checking bench for the IO protection control block
`timescale 1ns/1ps
`include "iop_cfg.svh"

module tb;
	// ------------------------------------------------------------
	// Signals and model state
	// ------------------------------------------------------------
	localparam logic [7:0] A_CTRL  = {2'h0, `IOP_OFS_CTRL, 2'h0};
	localparam logic [7:0] A_FLUSH = {2'h0, `IOP_OFS_FLUSH, 2'h0};
	localparam logic [7:0] A_STAT  = {2'h0, `IOP_OFS_STATUS, 2'h0};
	localparam logic [7:0] A_MASK  = {2'h0, `IOP_OFS_MASK, 2'h0};
	localparam logic [7:0] A_FAIL  = {2'h0, `IOP_OFS_FAIL, 2'h0};
	logic                 clk_i    = 1'b0;
	logic                 rst_i    = 1'b1;
	logic                 wb_cyc_i = 1'b0;
	logic                 wb_stb_i = 1'b0;
	logic                 wb_we_i  = 1'b0;
	logic [7:0]           wb_adr_i = 8'h00;
	logic [3:0]           wb_sel_i = 4'h0;
	logic [31:0]          wb_dat_i = 32'h0;
	logic [31:0]          wb_dat_o;
	logic                 wb_ack_o, fetch_err, parity_err, busy, grant, deny, check, flush_grp, flush_busy, irq;
	iop_pkg::iop_req_t    req;
	iop_pkg::iop_lookup_t lookup;
	logic [3:0]           flush_set, set_group;
	logic [31:0]          m_ctrl = 32'h0;  // Model of the control register
	logic [31:0]          m_stat = 32'h0;  // Model of the status flags
	logic [31:0]          m_mask = 32'h0;  // Model of the mask
	logic [31:0]          m_fail = 32'h0;  // Model of the failing record
	logic [31:0]          v;
	logic [4:0]           grp_seen = 5'h0; // Last flush target seen
	int                   num_errors = 0, num_checks = 0, irq_seen = 0, irq_exp = 0, busy_cnt = 0;

	always #2 clk_i = ~clk_i;

	iop_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.req_i(req), .fetch_err_i(fetch_err), .parity_err_i(parity_err), .busy_i(busy), .grant_o(grant),
		.deny_o(deny), .check_o(check), .lookup_o(lookup), .flush_set_o(flush_set), .flush_grp_o(flush_grp),
		.flush_busy_o(flush_busy), .set_group_o(set_group), .irq_o(irq));

	iop_far_model u_far (.clk_i(clk_i), .grant_i(grant), .deny_i(deny), .req_o(req), .fetch_err_o(fetch_err),
		.parity_err_o(parity_err), .busy_o(busy));

	// Interrupt pulses and flush activity seen at the ports
	always @(posedge clk_i) begin
		if (irq === 1'b1) begin
			irq_seen <= irq_seen + 1;
		end
		if (flush_busy === 1'b1) begin
			busy_cnt <= busy_cnt + 1;
			grp_seen <= {flush_grp, flush_set};
		end
	end

	// ------------------------------------------------------------
	// Comparison, bus and model tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Classic cycle: hold everything until ack is sampled high
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rdat);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= wd;
		wb_sel_i <= 4'hf;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		rdat = wb_dat_o;
		if (n >= 50) begin
			num_errors++;
		end
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_dat_i <= ~wd;
	endtask

	task automatic wr(input logic [7:0] adr, input logic [31:0] d);
		logic [31:0] x;
		wb(1'b1, adr, d, x);
	endtask

	task automatic rd(input logic [7:0] adr, input logic [31:0] exp, input string what);
		logic [31:0] x;
		wb(1'b0, adr, 32'h0, x);
		chk(what, x, exp);
	endtask

	// Software polls, bounded, until a bit shows the wanted value
	task automatic poll(input logic [7:0] adr, input int b, input logic val);
		logic [31:0] x;
		int n;
		n = 0;
		do begin
			wb(1'b0, adr, 32'h0, x);
			n++;
		end while (x[b] !== val && n < 40);
		chk("poll", 32'(x[b]), 32'(val));
	endtask

	task automatic wctl(input logic [31:0] d);
		wr(A_CTRL, d);
		m_ctrl = d;
	endtask

	// Write-one-clear on the sticky flags
	task automatic wst(input logic [31:0] d);
		wr(A_STAT, d);
		m_stat = m_stat & ~(d & 32'h2f);
	endtask

	function automatic void raise(input int b);
		if (!m_stat[b] && m_mask[b]) begin
			irq_exp++;
		end
		m_stat[b] = 1'b1;
	endfunction

	// One access through the partner; the decision comes from the model
	task automatic acc(input logic w, input logic bm, input logic fe);
		iop_pkg::iop_req_t r;
		logic g;
		logic d;
		logic den;
		logic live;
		r = '{1'b1, w, $urandom, 4'($urandom), 4'($urandom), 1'b1, 1'b1, 1'b0, bm};
		u_far.access(r, fe, g, d);
		live = !m_ctrl[5];
		den = m_ctrl[0] & (fe | (!bm & ((m_ctrl[2:1] == 2'h1) | !m_ctrl[6] | w)));
		chk("grant", 32'(g), 32'(live & !den));
		chk("deny", 32'(d), 32'(live & den));
		chk("check", 32'(check), 32'(m_ctrl[0] & live & ((m_ctrl[2:1] == 2'h1) | !m_ctrl[6] | w)));
		chk("set group", 32'(set_group), m_ctrl[4] ? 32'(r.group) : 32'h0);
		if (live && den) begin
			if (m_ctrl[7] || !m_stat[1]) begin
				m_fail = {r.addr[31:5], w, r.initiator};
			end
			if (fe) begin
				raise(0);
			end
			raise(1);
		end
	endtask

	task automatic report_and_stop();
		$display("Checks %0d, mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Watchdog well beyond the expected run length
	initial begin
		#80000;
		num_errors++;
		report_and_stop();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(32'he8913d93));
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		// Reset values, plus one unmapped place
		for (int i = 0; i < 6; i++) begin
			rd(8'(i * 4), 32'h0, "reset value");
		end
		wr(8'h14, 32'hffff_ffff);
		rd(A_CTRL, 32'h0, "ctrl after unmapped write");
		// Random control settings with the unit kept off
		for (int i = 0; i < 6; i++) begin
			v = $urandom & 32'h0000_0fde;
			wctl(v);
			rd(A_CTRL, m_ctrl, "ctrl readback");
			chk("lookup", 32'(lookup), {24'h0, !v[11], v[10] & v[3], v[9:8], v[3], v[4], v[2:1]});
		end
		wctl(32'h0);
		// Enable held off while the datapath is busy
		u_far.hold(1'b1);
		wctl(32'h1);
		m_ctrl = 32'h0;
		repeat (8) @(posedge clk_i);
		rd(A_CTRL, 32'h0, "enable held off");
		u_far.hold(1'b0);
		poll(A_CTRL, 0, 1'b1);
		m_ctrl = 32'h1;
		wr(A_MASK, 32'hffff_ffff);
		m_mask = 32'h2f;
		rd(A_MASK, m_mask, "mask");
		// Decisions and the failing record in both update policies
		acc(1'b0, 1'b1, 1'b0);
		acc(1'b1, 1'b0, 1'b0);
		acc(1'b0, 1'b0, 1'b0);
		rd(A_FAIL, m_fail, "fail record");
		wctl(32'h0000_00c1);
		acc(1'b0, 1'b0, 1'b0);
		acc(1'b1, 1'b0, 1'b0);
		rd(A_FAIL, m_fail, "fail record always");
		wctl(32'h0000_00c3);
		acc(1'b0, 1'b0, 1'b0);
		acc(1'b0, 1'b1, 1'b1);
		rd(A_STAT, m_stat, "status after denials");
		wst(32'h0);
		rd(A_STAT, m_stat, "status write zero");
		wst(32'h3);
		rd(A_STAT, m_stat, "status cleared");
		// Whole flush after a change of the invalid-entry policy
		wctl(m_ctrl | 32'h400);
		wr(A_FLUSH, 32'h1);
		rd(A_FLUSH, 32'h1, "flush pending");
		raise(2);
		rd(A_STAT, m_stat, "flush begun");
		poll(A_FLUSH, 0, 1'b0);
		raise(3);
		rd(A_STAT, m_stat, "flush done");
		chk("flush length", 32'(busy_cnt >= 32), 32'h1);
		// Group flush with group set addressing on
		wst(32'hc);
		wctl(m_ctrl | 32'h10);
		wr(A_FLUSH, 32'ha2);
		poll(A_FLUSH, 1, 1'b0);
		raise(2);
		raise(3);
		chk("group flush target", 32'(grp_seen), 32'h1a);
		rd(A_STAT, m_stat, "group flush flags");
		// Parity fault
		u_far.parity();
		raise(5);
		rd(A_STAT, m_stat, "parity flag");
		// Diagnostic mode blocks forwarding
		wctl(m_ctrl | 32'h20);
		poll(A_STAT, 4, 1'b1);
		m_stat[4] = 1'b1;
		acc(1'b1, 1'b0, 1'b0);
		wctl(m_ctrl & ~32'h20);
		m_stat[4] = 1'b0;
		poll(A_STAT, 4, 1'b0);
		rd(A_STAT, m_stat, "status after diagnostic");
		repeat (4) @(posedge clk_i);
		chk("irq pulses", 32'(irq_seen), 32'(irq_exp));
		report_and_stop();
	end
endmodule
